// *** design/vrs_seq_regs.svh ***
// constants of the start-up and fault sequencer: offsets, fields, resets, counts
// assumes levels are in 12.5mV units (0.0125V per lsb), counts in switching cycles
//
// Behaviour
// R01: in shutdown all phase pwm outputs are high-impedance.
// R02: soft-start starts at once when supply, enable, logic enable and code all valid.
// R03: codes 111111/111110 mean no load, shut down; other codes restart soft-start.
// R04: after no-load code wait two cycles, then shutdown trip level and pwm off.
// R05: soft-start opens with 64 cycles of reference held at zero.
// R06: reference then ramps linearly to target, 1280 cycles per volt.
// R07: pwm stays high-impedance until reference reaches existing output voltage.
// R08: first 640 ramp cycles step 25mV, afterwards 12.5mV steps.
// R09: sense offset starts at 100mV, falls to zero over first 640 cycles.
// R10: power-good low in shutdown, released only after successful soft-start.
// R11: power-good drops only on undervoltage or disable; overvoltage alone not.
// R12: power-good low while sense voltage below 75% of target.
// R13: supply above 1.4V but invalid: trip if remote sense exceeds 1.8V.
// R14: valid supply, not enabled: trip 1.7V, or target+200mV after ov trip.
// R15: soft-start trip is max(1.7V, target+200mV); running trip is target+200mV.
// R16: overvoltage drives pwm low until sense below 0.6V valid, 1.5V otherwise.
// R17: low pwm goes high-impedance at reference level, low again on recurrence.
// R18: crowbar output asserted together with the overvoltage pwm action.
// R19: overvoltage latch cleared only by enable, logic enable or supply cycling; code also clears it when software enable swEnable is low.
// R20: average current excess enters overcurrent shutdown immediately.
// R21: any phase over reference eight consecutive cycles enters overcurrent shutdown.
// R22: overcurrent: pwm high-impedance 4096 cycles, then retry soft-start while enabled.
// R23: counts use a switching-cycle tick; comparator inputs synchronous to ref_clk.
// R24: target level comes from an external decoder; block only compares and steps.
`ifndef VRS_SEQ_REGS_SVH
`define VRS_SEQ_REGS_SVH

// ---------------------------------------------
// register map (word offsets in bytes)
// ---------------------------------------------
`define VRS_OFS_CTRL      8'h00
`define VRS_OFS_STATUS    8'h04
`define VRS_OFS_REF       8'h08
`define VRS_CTRL_SWEN_BIT 0
`define VRS_CTRL_RESET    32'h0000_0001

// ---------------------------------------------
// codes and levels (12.5mV lsb)
// ---------------------------------------------
`define VRS_CODE_NOLOAD0  6'h3f
`define VRS_CODE_NOLOAD1  6'h3e
`define VRS_LVL_1V8       8'h90
`define VRS_LVL_1V7       8'h88
`define VRS_LVL_1V5       8'h78
`define VRS_LVL_0V6       8'h30
`define VRS_LVL_200MV     8'h10
`define VRS_LVL_OFS100    8'h08

// ---------------------------------------------
// cycle counts
// ---------------------------------------------
`define VRS_NOLOAD_WAIT   2
`define VRS_SS_DELAY      64
`define VRS_CYC_PER_VOLT  1280
`define VRS_COARSE_CYC    640
`define VRS_OC_PHASE_CYC  8
`define VRS_HICCUP_CYC    4096

`endif

// *** design/vrs_seq_pkg.sv ***
// types of the start-up and fault sequencer
// assumes the constants header is included by the design that uses it
package vrs_seq_pkg;

   typedef enum logic [2:0] {
      SEQ_OFF, SEQ_DELAY, SEQ_RAMP, SEQ_RUN, SEQ_HICCUP, SEQ_OVLATCH
   } vrs_state_t;

   typedef enum logic [1:0] {
      PWM_HIZ, PWM_LOW, PWM_SWITCH
   } vrs_pwm_t;

   // comparator results from the analog front end
   typedef struct packed {
      logic supplyValid;
      logic supplyAbove1v4;
      logic enableAbove;
      logic avgOverCurrent;
      logic refAtOutput;
   } vrs_cmp_t;

endpackage

// *** design/vrs_seq_top.sv ***
// start-up, soft-start and protection sequencer with a classic wishbone slave
// assumes all comparator levels arrive as digital inputs on ref_clk
`timescale 1ns/1ns
`include "vrs_seq_regs.svh"

module vrs_seq_top #(
   parameter int NPHASE    = 4,
   parameter int LVLW      = 8,
   parameter int HICCUPCYC = `VRS_HICCUP_CYC
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   // switching oscillator tick
   input  wire logic                  swTick,
   // analog comparators
   input  wire vrs_seq_pkg::vrs_cmp_t cmpIn,
   input  wire logic [NPHASE-1:0]     phaseOverCurrent,
   input  wire logic                  logic_level_enable,
   input  wire logic [5:0]            voltage_id_code,
   input  wire logic [LVLW-1:0]       targetLevel,
   input  wire logic [LVLW-1:0]       remote_sense_voltage,
   input  wire logic [LVLW-1:0]       diff_sense_output,
   // phase and protection outputs
   output vrs_seq_pkg::vrs_pwm_t      pwmMode,
   output logic                       supplyOkLow,
   output logic                       supplyOkOe,
   output logic                       crowbar_drive,
   output logic [LVLW-1:0]            refLevel,
   output logic [LVLW-1:0]            senseOffset,
   output logic [LVLW-1:0]            ovTripLevel,
   // wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o
);
   import vrs_seq_pkg::*;

   localparam int CW = 16;
   localparam logic [CW-1:0] DELAYN  = CW'(`VRS_SS_DELAY);
   localparam logic [CW-1:0] COARSEN = CW'(`VRS_COARSE_CYC);
   // 1280 cycles per volt at 12.5mV per lsb gives 16 cycles per fine step
   localparam logic [CW-1:0] FINEDIV = CW'(`VRS_CYC_PER_VOLT / 80);
   // offset loses one lsb per interval so it is spent exactly at the end of the coarse ramp
   localparam logic [CW-1:0] OFSDIV  = CW'(`VRS_COARSE_CYC / `VRS_LVL_OFS100);
   localparam logic [CW-1:0] HICN    = CW'(HICCUPCYC);

   function automatic logic [LVLW-1:0] maxLvl(input logic [LVLW-1:0] a, input logic [LVLW-1:0] b);
      maxLvl = (a > b) ? a : b;
   endfunction

   // ---------------------------------------------
   // wishbone register file
   // ---------------------------------------------
   logic [31:0]     ctrl_reg;
   logic            ack_reg;
   logic [31:0]     rdat_reg;
   vrs_state_t      state_reg;
   logic            ovLatch_reg;
   logic            pwrGood_reg;
   logic            crowbar_reg;
   logic [31:0]     rdSel;
   wire             wbReq   = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire             hitCtrl = wb_adr_i == `VRS_OFS_CTRL;
   wire             hitStat = wb_adr_i == `VRS_OFS_STATUS;
   wire             hitRef  = wb_adr_i == `VRS_OFS_REF;
   wire             swEnable = ctrl_reg[`VRS_CTRL_SWEN_BIT];

   assign rdSel = hitCtrl ? ctrl_reg :
                  hitStat ? {24'h0, 2'h0, crowbar_reg, pwrGood_reg, ovLatch_reg, state_reg} :
                  hitRef  ? {8'h0, ovTripLevel, senseOffset, refLevel} : 32'h0;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `VRS_CTRL_RESET;
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0;
      end else begin
         ack_reg  <= wbReq;
         rdat_reg <= wbReq ? rdSel : rdat_reg;
         if (wbReq && wb_we_i && hitCtrl && wb_sel_i[0]) begin
            ctrl_reg <= {24'h0, wb_dat_i[7:0]};
         end
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ---------------------------------------------
   // enable conditions
   // ---------------------------------------------
   wire noLoadCode = (voltage_id_code == `VRS_CODE_NOLOAD0) ||
                     (voltage_id_code == `VRS_CODE_NOLOAD1);                     // R03
   wire hardEnable = cmpIn.supplyValid & cmpIn.enableAbove & logic_level_enable & swEnable;
   wire allEnable  = hardEnable & ~noLoadCode;                                   // R02

   // no-load code takes effect two switching cycles later
   logic [1:0] noLoadCnt_reg;
   wire        noLoadDone = noLoadCnt_reg == 2'(`VRS_NOLOAD_WAIT);               // R04
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         noLoadCnt_reg <= 2'h0;
      end else if (!noLoadCode) begin
         noLoadCnt_reg <= 2'h0;
      end else if (swTick && !noLoadDone) begin
         noLoadCnt_reg <= noLoadCnt_reg + 2'h1;                                  // R23
      end
   end
   wire shutNow = ~hardEnable | (noLoadCode & noLoadDone);

   // ---------------------------------------------
   // overvoltage detect
   // ---------------------------------------------
   wire [LVLW-1:0] tgtPlus = targetLevel + `VRS_LVL_200MV;
   logic [LVLW-1:0] tripSel;
   always_comb begin
      if (state_reg == SEQ_OVLATCH || ovLatch_reg) begin
         tripSel = tgtPlus;                                                      // R14
      end else if (state_reg == SEQ_DELAY || state_reg == SEQ_RAMP) begin
         tripSel = maxLvl(`VRS_LVL_1V7, tgtPlus);                                // R15
      end else if (state_reg == SEQ_RUN) begin
         tripSel = tgtPlus;                                                      // R15
      end else begin
         tripSel = `VRS_LVL_1V7;                                                 // R14
      end
   end
   wire ovAux   = ~cmpIn.supplyValid & cmpIn.supplyAbove1v4 &
                  (remote_sense_voltage > `VRS_LVL_1V8);                         // R13
   wire ovMain  = cmpIn.supplyValid & (diff_sense_output > tripSel);
   wire ovEvent = ovAux | ovMain;
   wire [LVLW-1:0] ovRelLv = cmpIn.supplyValid ? `VRS_LVL_0V6 : `VRS_LVL_1V5;
   wire ovStillHigh = remote_sense_voltage >= ovRelLv;                           // R16

   // ---------------------------------------------
   // overcurrent detect
   // ---------------------------------------------
   logic [3:0] phCnt_reg [NPHASE];
   logic [NPHASE-1:0] phTrip;
   for (genvar p = 0; p < NPHASE; p++) begin : g_ph
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            phCnt_reg[p] <= 4'h0;
         end else if (!phaseOverCurrent[p]) begin
            phCnt_reg[p] <= 4'h0;
         end else if (swTick && !phTrip[p]) begin
            phCnt_reg[p] <= phCnt_reg[p] + 4'h1;
         end
      end
      assign phTrip[p] = phCnt_reg[p] >= 4'(`VRS_OC_PHASE_CYC);                  // R21
   end
   wire ocEvent = cmpIn.avgOverCurrent | (|phTrip);                              // R20

   // ---------------------------------------------
   // sequencer
   // ---------------------------------------------
   logic [CW-1:0]   cnt_reg;
   logic [CW-1:0]   rampCnt_reg;
   logic [LVLW-1:0] ref_reg;
   logic [LVLW-1:0] ofs_reg;
   logic            switching_reg;
   logic            ovLow_reg;
   vrs_state_t      state_next;
   logic            uvLow;
   wire [LVLW+1:0]  sense4 = {remote_sense_voltage, 2'b00};
   wire [LVLW+1:0]  tgt3   = {2'b00, targetLevel} + {1'b0, targetLevel, 1'b0};
   assign uvLow = sense4 < tgt3;                                                 // R12
   wire coarse  = rampCnt_reg < COARSEN;                                         // R08
   wire stepNow = coarse ? (rampCnt_reg % (FINEDIV + FINEDIV) == FINEDIV + FINEDIV - 16'h1) :
                           (rampCnt_reg % FINEDIV == FINEDIV - 16'h1);
   wire ofsStep = rampCnt_reg % OFSDIV == OFSDIV - 16'h1;                        // R09
   wire [LVLW-1:0] stepSz = coarse ? LVLW'(2) : LVLW'(1);
   wire rampDone = ref_reg >= targetLevel;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SEQ_OFF:     state_next = allEnable ? SEQ_DELAY : SEQ_OFF;              // R02
         SEQ_DELAY:   state_next = (swTick && cnt_reg == DELAYN - 16'h1) ? SEQ_RAMP : SEQ_DELAY;
         SEQ_RAMP:    state_next = rampDone ? SEQ_RUN : SEQ_RAMP;
         SEQ_RUN:     state_next = SEQ_RUN;
         SEQ_HICCUP:  state_next = (swTick && cnt_reg == HICN - 16'h1) ?
                                   (allEnable ? SEQ_DELAY : SEQ_OFF) : SEQ_HICCUP; // R22
         SEQ_OVLATCH: state_next = SEQ_OVLATCH;                                  // R19
         default:     state_next = SEQ_OFF;
      endcase
      if (state_reg != SEQ_OVLATCH && state_reg != SEQ_OFF && state_reg != SEQ_HICCUP && ocEvent) begin
         state_next = SEQ_HICCUP;                                                // R20
      end
      if (ovEvent) begin
         state_next = SEQ_OVLATCH;
      end
      if (shutNow && !(ovLatch_reg && hardEnable)) begin
         state_next = SEQ_OFF;                                                   // R03
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= SEQ_OFF;
         cnt_reg   <= 16'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg) ? 16'h0 : (swTick ? cnt_reg + 16'h1 : cnt_reg);
      end
   end

   // reference ramp and sense offset
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ref_reg     <= '0;
         ofs_reg     <= '0;
         rampCnt_reg <= 16'h0;
      end else if (state_reg == SEQ_DELAY || state_reg == SEQ_OFF || state_reg == SEQ_HICCUP) begin
         ref_reg     <= '0;                                                      // R05
         ofs_reg     <= `VRS_LVL_OFS100;                                         // R09
         rampCnt_reg <= 16'h0;
      end else if (state_reg == SEQ_RAMP && swTick) begin
         rampCnt_reg <= rampCnt_reg + 16'h1;
         if (stepNow) begin
            ref_reg <= maxLvl(ref_reg, (ref_reg + stepSz > targetLevel) ? targetLevel : ref_reg + stepSz); // R06
         end
         if (ofsStep && ofs_reg != '0) begin
            ofs_reg <= ofs_reg - LVLW'(1);                                       // R09
         end
      end else if (state_reg == SEQ_RUN) begin
         ref_reg <= targetLevel;                                                 // R24
         ofs_reg <= '0;
      end
   end

   // pwm gating, overvoltage latch, crowbar, power-good
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         switching_reg <= 1'b0;
         ovLatch_reg   <= 1'b0;
         ovLow_reg     <= 1'b0;
         crowbar_reg   <= 1'b0;
         pwrGood_reg   <= 1'b0;
      end else begin
         if (state_next != SEQ_RAMP && state_next != SEQ_RUN) begin
            switching_reg <= 1'b0;                                               // R01
         end else if (cmpIn.refAtOutput) begin
            switching_reg <= 1'b1;                                               // R07
         end
         if (ovEvent) begin
            ovLatch_reg <= 1'b1;                                                 // R19
         end else if (~hardEnable) begin
            ovLatch_reg <= 1'b0;
         end
         if (ovEvent) begin
            ovLow_reg   <= 1'b1;                                                 // R17
            crowbar_reg <= 1'b1;                                                 // R18
         end else if (!ovStillHigh && diff_sense_output <= ref_reg) begin
            ovLow_reg   <= 1'b0;                                                 // R16
            crowbar_reg <= 1'b0;
         end
         if (state_next == SEQ_OFF || (ovLatch_reg && shutNow)) begin
            pwrGood_reg <= 1'b0;                                                 // R10
         end else if (uvLow) begin
            pwrGood_reg <= 1'b0;                                                 // R12
         end else if (state_reg == SEQ_RUN || (pwrGood_reg == 1'b0 && state_reg == SEQ_RUN)) begin
            pwrGood_reg <= 1'b1;                                                 // R11
         end
      end
   end

   assign pwmMode     = ovLow_reg ? PWM_LOW : (switching_reg ? PWM_SWITCH : PWM_HIZ); // R16
   assign supplyOkLow = 1'b0;
   assign supplyOkOe  = ~pwrGood_reg;                                            // R11
   assign crowbar_drive = crowbar_reg;
   assign refLevel    = ref_reg;
   assign senseOffset = ofs_reg;
   assign ovTripLevel = tripSel;

endmodule // vrs_seq_top

// *** verif/vrs_seq_assertions.sv ***
// concurrent checks on the sequencer top ports
// assumes a bind into vrs_seq_top and the single ref_clk domain
`timescale 1ns/1ns
`include "vrs_seq_regs.svh"
module vrs_seq_assertions
   import vrs_seq_pkg::*;
#(
   parameter int NPHASE = 4,
   parameter int LVLW   = 8
) (
   // clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rstn,
   // watched inputs
   input wire logic                  swTick,
   input wire vrs_seq_pkg::vrs_cmp_t cmpIn,
   input wire logic [NPHASE-1:0]     phaseOverCurrent,
   input wire logic                  logic_level_enable,
   input wire logic [LVLW-1:0]       targetLevel,
   input wire logic [LVLW-1:0]       remote_sense_voltage,
   input wire logic [LVLW-1:0]       diff_sense_output,
   // watched outputs
   input wire vrs_seq_pkg::vrs_pwm_t pwmMode,
   input wire logic                  supplyOkOe,
   input wire logic                  crowbar_drive,
   input wire logic [LVLW-1:0]       refLevel,
   input wire logic [LVLW-1:0]       senseOffset,
   input wire logic [LVLW-1:0]       ovTripLevel
);
   logic [3:0] ocCnt_reg;
   logic       uvNow;
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // 75 percent test done as 4x against 3x, no division
   assign uvNow = {remote_sense_voltage, 2'b00} < ({2'b00, targetLevel} + {1'b0, targetLevel, 1'b0});
   // saturating count of ticks with a phase over reference
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         ocCnt_reg <= 4'h0;
      else if (phaseOverCurrent == '0)
         ocCnt_reg <= 4'h0;
      else if (swTick && ocCnt_reg != 4'hf)
         ocCnt_reg <= ocCnt_reg + 4'h1;
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_ovSeen;
      cmpIn.supplyValid && diff_sense_output > ovTripLevel;
   endsequence
   sequence s_ovAct;
      crowbar_drive && pwmMode == PWM_LOW;
   endsequence
   AST_DIS_HIZ: assert property ((!logic_level_enable && !crowbar_drive) [*3] |-> pwmMode == PWM_HIZ)
      else $error("pwm driven while disabled");
   AST_PG_OFF: assert property ((!logic_level_enable || !cmpIn.supplyValid) [*3] |-> supplyOkOe)
      else $error("power good released while disabled");
   AST_REF_TICK: assert property ($changed(refLevel) && refLevel != '0 |-> $past(swTick))
      else $error("reference moved without a tick");
   AST_REF_STEP: assert property ($changed(refLevel) && refLevel != '0 |->
      (refLevel - $past(refLevel)) inside {8'h01, 8'h02})
      else $error("reference step size wrong");
   AST_OFS_FALL: assert property ($changed(senseOffset) && senseOffset != `VRS_LVL_OFS100 |->
      senseOffset == $past(senseOffset) - 8'h01)
      else $error("sense offset not decaying by one");
   AST_PG_UV: assert property (uvNow |-> ##[1:3] supplyOkOe)
      else $error("power good kept under undervoltage");
   AST_OV_ACT: assert property (s_ovSeen |-> ##[1:2] s_ovAct)
      else $error("overvoltage without crowbar and low pwm");
   AST_OV_KEEP_PG: assert property ($rose(crowbar_drive) && !supplyOkOe |=> !supplyOkOe)
      else $error("power good dropped by overvoltage");
   AST_AVG_OC: assert property (cmpIn.avgOverCurrent && !crowbar_drive |->
      ##[1:2] (pwmMode == PWM_HIZ) [*8])
      else $error("average overcurrent not shutting pwm");
   AST_PHASE_OC: assert property (ocCnt_reg == 4'ha |-> pwmMode == PWM_HIZ)
      else $error("phase overcurrent not shutting pwm");
endmodule // vrs_seq_assertions

// *** verif/vrs_plant_model.sv ***
// behavioural output stage: drivers, inductors and output capacitor
// assumes pwmMode from the sequencer; charge is held while drivers float
`timescale 1ns/1ns
module vrs_plant_model
   import vrs_seq_pkg::*;
(
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   // controls
   input  wire vrs_seq_pkg::vrs_pwm_t pwmMode,
   input  wire logic [7:0]            refLevel,
   input  wire logic                  ovForce,
   input  wire logic                  sag,
   // sensed output
   output logic [7:0]                 senseLvl,
   output logic                       refAtOut
);
   logic [7:0] senseLvl_reg;
   assign senseLvl = senseLvl_reg;
   assign refAtOut = refLevel >= senseLvl_reg;
   // precharged output so the start-up must wait for the reference
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         senseLvl_reg <= 8'h08;
      else if (ovForce)
         senseLvl_reg <= 8'hc0;
      else if (sag)
         senseLvl_reg <= 8'h04;
      else if (pwmMode == PWM_SWITCH)
         senseLvl_reg <= refLevel;
      else if (pwmMode == PWM_LOW && senseLvl_reg != 8'h00)
         senseLvl_reg <= senseLvl_reg - 8'h01;
   end
endmodule // vrs_plant_model

// *** verif/vrs_seq_top_bench.sv ***
// self-checking bench for the start-up and fault sequencer
// assumes the plant model closes the sense loop; bus reads checked from a queue
`timescale 1ns/1ns
`include "vrs_seq_regs.svh"
module vrs_seq_top_bench;
   import vrs_seq_pkg::*;
   localparam int HC = 16;
   logic        ref_clk = 1'b0, rstn = 1'b0, swTick = 1'b0, supV = 1'b1, avgOc = 1'b0, refAt;
   logic        logic_level_enable = 1'b0, ovForce = 1'b0, sag = 1'b0, supplyOkOe, crowbar_drive;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [3:0]  phaseOverCurrent = 4'h0;
   logic [5:0]  voltage_id_code = 6'h10;
   logic [5:0]  nl[2] = '{`VRS_CODE_NOLOAD0, `VRS_CODE_NOLOAD1};
   logic [7:0]  targetLevel = 8'h30, sense, wb_adr_i = 8'h00, refLevel, senseOffset, ovTripLevel;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [31:0] expQ[$], mskQ[$];
   vrs_pwm_t    pwmMode;
   vrs_cmp_t    cmpIn;
   int          errors = 0, checks = 0;
   assign cmpIn = vrs_cmp_t'({supV, 1'b1, 1'b1, avgOc, refAt});
   vrs_seq_top #(.HICCUPCYC(HC)) u_dut (.ref_clk, .rstn, .swTick, .cmpIn, .phaseOverCurrent, .logic_level_enable,
      .voltage_id_code, .targetLevel, .remote_sense_voltage(sense), .diff_sense_output(sense), .pwmMode,
      .supplyOkLow(), .supplyOkOe, .crowbar_drive, .refLevel, .senseOffset, .ovTripLevel, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o);
   vrs_plant_model u_plant (.ref_clk, .rstn, .pwmMode, .refLevel, .ovForce, .sag, .senseLvl(sense),
      .refAtOut(refAt));
   always #2 ref_clk = ~ref_clk;
   // tick every other clock keeps switching counts short
   always @(posedge ref_clk) swTick <= ~swTick;
   always @(negedge ref_clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0)
         cmp(wb_dat_o & mskQ.pop_front(), expQ.pop_front());
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      if (!we) begin
         expQ.push_back(d & m);
         mskQ.push_back(m);
      end
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20)
         cmp(32'h0, 32'h1);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk iff swTick);
   endtask
   function automatic logic [1:0] pick(input int s);
      return s == 0 ? {1'b0, supplyOkOe} : s == 1 ? pwmMode : {1'b0, crowbar_drive};
   endfunction
   task automatic waitSig(input int s, input logic [1:0] v, input int lim);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (pick(s) !== v && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      cmp({31'h0, n >= lim}, 32'h0);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      final_report();
   end
   initial begin
      void'($urandom(32'hf960));
      targetLevel = 8'h30 + 8'($urandom % 8);
      @(negedge ref_clk);
      cmp(pwmMode, PWM_HIZ);
      cmp(supplyOkOe, 1'b1);
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      wb(1'b0, `VRS_OFS_CTRL, `VRS_CTRL_RESET, 32'h1);
      wb(1'b0, 8'h0c, 32'h0, 32'hffff_ffff);
      wb(1'b1, `VRS_OFS_STATUS, 32'hff, 32'h0);
      wb(1'b0, `VRS_OFS_STATUS, 32'h0, 32'h7);
      cmp(ovTripLevel, `VRS_LVL_1V7);
      logic_level_enable <= 1'b1;
      ticks(60);
      @(negedge ref_clk);
      cmp(refLevel, 8'h00);
      cmp(senseOffset, `VRS_LVL_OFS100);
      cmp(pwmMode, PWM_HIZ);
      cmp(ovTripLevel, `VRS_LVL_1V7);
      wb(1'b0, `VRS_OFS_STATUS, 32'h1, 32'h7);
      ticks(650);
      @(negedge ref_clk);
      cmp(refLevel, 8'h28);
      cmp(senseOffset, 8'h00);
      cmp(pwmMode, PWM_SWITCH);
      waitSig(0, 2'b00, 4000);
      cmp(refLevel, targetLevel);
      cmp(ovTripLevel, targetLevel + `VRS_LVL_200MV);
      wb(1'b0, `VRS_OFS_STATUS, 32'h13, 32'h1f);
      sag <= 1'b1;
      waitSig(0, 2'b01, 20);
      @(posedge ref_clk);
      sag <= 1'b0;
      waitSig(0, 2'b00, 20);
      @(posedge ref_clk);
      avgOc <= 1'b1;
      ticks(1);
      avgOc <= 1'b0;
      waitSig(1, PWM_HIZ, 4);
      ticks(HC - 6);
      wb(1'b0, `VRS_OFS_STATUS, 32'h4, 32'h7);
      ticks(8);
      wb(1'b0, `VRS_OFS_STATUS, 32'h1, 32'h7);
      waitSig(1, PWM_SWITCH, 4000);
      @(posedge ref_clk);
      phaseOverCurrent <= 4'h1 << ($urandom % 4);
      ticks(6);
      @(negedge ref_clk);
      cmp(pwmMode, PWM_SWITCH);
      ticks(5);
      @(negedge ref_clk);
      cmp(pwmMode, PWM_HIZ);
      @(posedge ref_clk);
      phaseOverCurrent <= 4'h0;
      waitSig(1, PWM_SWITCH, 4000);
      foreach (nl[i]) begin
         @(posedge ref_clk);
         voltage_id_code <= nl[i];
         ticks(1);
         @(negedge ref_clk);
         cmp(pwmMode, PWM_SWITCH);
         ticks(3);
         @(negedge ref_clk);
         cmp(pwmMode, PWM_HIZ);
         cmp(supplyOkOe, 1'b1);
         wb(1'b0, `VRS_OFS_STATUS, 32'h0, 32'h7);
         voltage_id_code <= 6'h10;
         wb(1'b0, `VRS_OFS_STATUS, 32'h1, 32'h7);
         waitSig(0, 2'b00, 4000);
      end
      @(posedge ref_clk);
      ovForce <= 1'b1;
      waitSig(2, 2'b01, 4);
      cmp(pwmMode, PWM_LOW);
      cmp(supplyOkOe, 1'b0);
      @(posedge ref_clk);
      ovForce <= 1'b0;
      waitSig(1, PWM_HIZ, 400);
      @(posedge ref_clk);
      voltage_id_code <= `VRS_CODE_NOLOAD0;
      ticks(4);
      voltage_id_code <= 6'h11;
      wb(1'b0, `VRS_OFS_STATUS, 32'h8, 32'h8);
      logic_level_enable <= 1'b0;
      ticks(2);
      logic_level_enable <= 1'b1;
      wb(1'b0, `VRS_OFS_STATUS, 32'h1, 32'hf);
      supV <= 1'b0;
      ovForce <= 1'b1;
      waitSig(2, 2'b01, 6);
      waitSig(0, 2'b01, 6);
      final_report();
   end
endmodule // vrs_seq_top_bench
bind vrs_seq_top vrs_seq_assertions #(.NPHASE(NPHASE), .LVLW(LVLW)) u_chk (.ref_clk, .rstn, .swTick, .cmpIn,
   .phaseOverCurrent, .logic_level_enable, .targetLevel, .remote_sense_voltage, .diff_sense_output, .pwmMode,
   .supplyOkOe, .crowbar_drive, .refLevel, .senseOffset, .ovTripLevel);
